// ==== src/can_mode_consts.svh ====
// offsets, field positions, reset values and timing counts of the mode control block
// assumes the includer works at 32-bit apb data width
`ifndef CAN_MODE_CONSTS_SVH
`define CAN_MODE_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CONTROL 4'h0
`define OFS_STATUS 4'h4
`define OFS_IRQ_EN 4'h8
`define OFS_DIAG 4'hc

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTL_INIT 0
`define CTL_SLEEP 1
`define CTL_AWU 2
`define STS_INIT_ACK 0
`define STS_SLEEP_ACK 1
`define STS_WKUP 2
`define STS_RX 3
`define IEN_WKUP 0
`define DIAG_LBK 0
`define DIAG_SIL 1
`define DIAG_RX 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTL_RESET 3'h2
`define IEN_RESET 1'h0
`define DIAG_RESET 2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define BIT_TIME_NS 1000
`define BIT_CYCLES ((`BIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_BITS 4'hb

`endif

// ==== src/can_mode_pkg.sv ====
// types shared by the mode control block
// assumes nothing beyond a systemverilog compiler
package can_mode_pkg;

  typedef enum logic [1:0]
  {
    st_sleep = 2'b00,
    st_init = 2'b01,
    st_sync = 2'b10,
    st_normal = 2'b11
  } mode_state_type;

endpackage

// ==== src/can_mode_control.sv ====
// operating-mode control of the can controller, with apb register access
// assumes a protocol core outside that drives core_tx and obeys the enables
//
// Summary of operation
// - come up asleep after hardware reset
// - acknowledge init or sleep only once entered
// - normal exactly when both acknowledges clear
// - wait 11 recessive bits before normal
// - init left when hardware clears init acknowledge
// - init mode: no traffic, transmit pin recessive
// - entering init keeps configuration registers
// - asleep: clock stopped, status frozen; here only the bit counter halts, the wake-up flag and rx status still update
// - init request while asleep stays unacknowledged
// - auto wake-up clears sleep request on activity
// - wake-up interrupt on activity when enabled
// - sleep exit: synchronize, then clear sleep acknowledge
// - test bits set in init only
// - silent: receive, never drive dominant
// - silent: dominant bits fed back internally
// - loop back: own frames received
// - loop back: acknowledge errors ignored
// - loop back: tx fed to rx, pin ignored
// - combined: rx disconnected, tx held recessive
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "can_mode_consts.svh"

module can_mode_control
  import can_mode_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // can bus pins
  input wire logic bus_receive_pin,
  output logic bus_transmit_pin,
  // protocol core side
  input wire logic core_tx,
  output logic core_rx,
  output logic core_active,
  output logic tx_start_allow,
  output logic ack_error_ignore,
  // wake-up interrupt request
  output logic wakeup_irq
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  mode_state_type state_reg;
  mode_state_type state_next;
  logic init_request_reg;
  logic sleep_request_reg;
  logic auto_wakeup_enable_reg;
  logic wakeup_irq_enable_reg;
  logic loopback_select_reg;
  logic silent_select_reg;
  logic init_acknowledge_reg;
  logic sleep_acknowledge_reg;
  logic wakeup_flag_reg;
  logic [3:0] bit_cnt_reg;
  logic [3:0] sync_cnt_reg;
  logic bit_tick;
  logic rx_eff;
  logic bus_activity;
  logic wr_en;
  logic rd_phase;
  logic addr_ok;
  logic [31:0] rd_data;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // one wait state so that read data comes straight from a flip-flop
  assign rd_phase = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign addr_ok = (paddr[31:4] == 28'h0) && (paddr[1:0] == 2'h0);

  always_comb
  begin
    rd_data = 32'h0;
    case (paddr[3:0])
      `OFS_CONTROL:
      begin
        rd_data[`CTL_INIT] = init_request_reg;
        rd_data[`CTL_SLEEP] = sleep_request_reg;
        rd_data[`CTL_AWU] = auto_wakeup_enable_reg;
      end
      `OFS_STATUS:
      begin
        rd_data[`STS_INIT_ACK] = init_acknowledge_reg;
        rd_data[`STS_SLEEP_ACK] = sleep_acknowledge_reg;
        rd_data[`STS_WKUP] = wakeup_flag_reg;
        rd_data[`STS_RX] = core_rx;
      end
      `OFS_IRQ_EN:
        rd_data[`IEN_WKUP] = wakeup_irq_enable_reg;
      `OFS_DIAG:
      begin
        rd_data[`DIAG_LBK] = loopback_select_reg;
        rd_data[`DIAG_SIL] = silent_select_reg;
        rd_data[`DIAG_RX] = bus_receive_pin;
      end
      default:
        rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (rd_phase)
    begin
      pready <= 1'b1;
      prdata <= addr_ok ? rd_data : 32'h0;
      pslverr <= !addr_ok;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // control and configuration
  // ----------------------------------------
  assign bus_activity = (state_reg == st_sleep) && !bus_receive_pin;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      {auto_wakeup_enable_reg, sleep_request_reg, init_request_reg} <= `CTL_RESET;
    end
    else
    begin
      if (wr_en && paddr[3:0] == `OFS_CONTROL)
      begin
        init_request_reg <= pwdata[`CTL_INIT];
        sleep_request_reg <= pwdata[`CTL_SLEEP];
        auto_wakeup_enable_reg <= pwdata[`CTL_AWU];
      end
      // hardware clear placed last so a racing write cannot re-arm sleep
      if (bus_activity && auto_wakeup_enable_reg)
        sleep_request_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      wakeup_irq_enable_reg <= `IEN_RESET;
    else if (wr_en && paddr[3:0] == `OFS_IRQ_EN)
      wakeup_irq_enable_reg <= pwdata[`IEN_WKUP];
  end

  // test bits only take a write while init is acknowledged
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      {silent_select_reg, loopback_select_reg} <= `DIAG_RESET;
    else if (wr_en && paddr[3:0] == `OFS_DIAG && init_acknowledge_reg)
    begin
      loopback_select_reg <= pwdata[`DIAG_LBK];
      silent_select_reg <= pwdata[`DIAG_SIL];
    end
  end

  // ----------------------------------------
  // wake-up flag and interrupt
  // ----------------------------------------
  // set wins over the write-one clear
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      wakeup_flag_reg <= 1'b0;
    else if (bus_activity)
      wakeup_flag_reg <= 1'b1;
    else if (wr_en && paddr[3:0] == `OFS_STATUS && pwdata[`STS_WKUP])
      wakeup_flag_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      wakeup_irq <= 1'b0;
    else
      wakeup_irq <= wakeup_flag_reg && wakeup_irq_enable_reg;
  end

  // ----------------------------------------
  // bit timing and receive path
  // ----------------------------------------
  // fixed nominal bit time; the real bit timing logic lives elsewhere
  assign bit_tick = (bit_cnt_reg == 4'((`BIT_CYCLES) - 1));

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      bit_cnt_reg <= 4'h0;
    else if (state_reg == st_sleep || bit_tick)
      bit_cnt_reg <= 4'h0;
    else
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
  end

  always_comb
  begin
    if (loopback_select_reg)
      rx_eff = core_tx;
    else if (silent_select_reg)
      rx_eff = bus_receive_pin && core_tx;
    else
      rx_eff = bus_receive_pin;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      core_rx <= 1'b1;
    else
      core_rx <= rx_eff;
  end

  // ----------------------------------------
  // mode state machine
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      st_sleep:
        if (!sleep_request_reg)
          state_next = st_sync;
      st_init:
        if (!init_request_reg)
          state_next = st_sync;
        else if (sleep_request_reg)
          state_next = st_sleep;
      st_sync:
        if (init_request_reg)
          state_next = st_init;
        else if (sleep_request_reg)
          state_next = st_sleep;
        else if (sync_cnt_reg == `SYNC_BITS)
          state_next = st_normal;
      st_normal:
        if (init_request_reg)
          state_next = st_init;
        else if (sleep_request_reg)
          state_next = st_sleep;
      default:
        state_next = st_sleep;
    endcase
  end

  // mode changes never write configuration registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      state_reg <= st_sleep;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || state_reg != st_sync)
      sync_cnt_reg <= 4'h0;
    else if (bit_tick)
      sync_cnt_reg <= rx_eff ? sync_cnt_reg + 4'h1 : 4'h0;
  end

  // acknowledges follow the entered state; both clear only after sync
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      init_acknowledge_reg <= 1'b0;
      sleep_acknowledge_reg <= 1'b1;
    end
    else
    begin
      case (state_reg)
        st_init:
        begin
          init_acknowledge_reg <= 1'b1;
          sleep_acknowledge_reg <= 1'b0;
        end
        st_sleep:
        begin
          init_acknowledge_reg <= 1'b0;
          sleep_acknowledge_reg <= 1'b1;
        end
        st_normal:
        begin
          init_acknowledge_reg <= 1'b0;
          sleep_acknowledge_reg <= 1'b0;
        end
        default:
        begin
          init_acknowledge_reg <= init_acknowledge_reg;
          sleep_acknowledge_reg <= sleep_acknowledge_reg;
        end
      endcase
    end
  end

  // ----------------------------------------
  // bus and core outputs
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      bus_transmit_pin <= 1'b1;
      core_active <= 1'b0;
      tx_start_allow <= 1'b0;
      ack_error_ignore <= 1'b0;
    end
    else
    begin
      // recessive unless fully in normal mode and not silent
      // follows the entered state, in step with the acknowledges
      bus_transmit_pin <= (state_reg != st_normal) || silent_select_reg || core_tx;
      core_active <= (state_reg == st_normal);
      tx_start_allow <= (state_reg == st_normal) && !silent_select_reg;
      ack_error_ignore <= loopback_select_reg;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_reset_sleep;
    @(posedge clk) !rst_b |=> state_reg == st_sleep && sleep_acknowledge_reg
      && !init_acknowledge_reg && sleep_request_reg;
  endproperty
  a_reset_sleep: assert property (p_reset_sleep) else $error("not asleep after reset");

  property p_normal_iff_acks;
    @(posedge clk) disable iff (!rst_b)
      (state_reg == st_normal) |=> core_active == (!init_acknowledge_reg && !sleep_acknowledge_reg);
  endproperty
  a_normal_iff_acks: assert property (p_normal_iff_acks) else $error("normal flag mismatch");

  property p_sync_first;
    @(posedge clk) disable iff (!rst_b)
      (state_reg != st_normal) ##1 (state_reg == st_normal)
      |-> $past(sync_cnt_reg) == `SYNC_BITS && $past(state_reg) == st_sync;
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("normal without bus idle");

  property p_init_ack;
    @(posedge clk) disable iff (!rst_b)
      $rose(init_acknowledge_reg) |-> $past(state_reg) == st_init;
  endproperty
  a_init_ack: assert property (p_init_ack) else $error("init acknowledged early");

  property p_init_recessive;
    @(posedge clk) disable iff (!rst_b)
      (state_reg == st_init) |=> bus_transmit_pin && !core_active;
  endproperty
  a_init_recessive: assert property (p_init_recessive) else $error("tx active in init");

  property p_sleep_no_init_ack;
    @(posedge clk) disable iff (!rst_b)
      (state_reg == st_sleep) && sleep_request_reg |=> !init_acknowledge_reg;
  endproperty
  a_sleep_no_init_ack: assert property (p_sleep_no_init_ack) else $error("init acked asleep");

  property p_auto_wake;
    @(posedge clk) disable iff (!rst_b)
      bus_activity && auto_wakeup_enable_reg |=> !sleep_request_reg ##1 state_reg == st_sync;
  endproperty
  a_auto_wake: assert property (p_auto_wake) else $error("auto wake-up missed");

  property p_wake_irq;
    @(posedge clk) disable iff (!rst_b)
      bus_activity && wakeup_irq_enable_reg
      && !(wr_en && paddr[3:0] == `OFS_IRQ_EN) |=> ##1 wakeup_irq;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake-up irq missed");

  property p_sleep_acknowledge_after_sync;
    @(posedge clk) disable iff (!rst_b)
      $fell(sleep_acknowledge_reg) |-> $past(state_reg, 2) == st_sync
        || $past(state_reg) == st_init;
  endproperty
  a_sleep_acknowledge_after_sync: assert property (p_sleep_acknowledge_after_sync) else $error("sleep left unsynced");

  property p_diag_locked;
    @(posedge clk) disable iff (!rst_b)
      !init_acknowledge_reg |=> $stable(loopback_select_reg) && $stable(silent_select_reg);
  endproperty
  a_diag_locked: assert property (p_diag_locked) else $error("test bits changed");

  property p_silent_tx;
    @(posedge clk) disable iff (!rst_b)
      silent_select_reg |=> bus_transmit_pin && !tx_start_allow;
  endproperty
  a_silent_tx: assert property (p_silent_tx) else $error("silent mode drove bus");

  property p_silent_feedback;
    @(posedge clk) disable iff (!rst_b)
      silent_select_reg && !loopback_select_reg && !core_tx |=> !core_rx;
  endproperty
  a_silent_feedback: assert property (p_silent_feedback) else $error("dominant not fed back");

  property p_loopback_rx;
    @(posedge clk) disable iff (!rst_b)
      loopback_select_reg |=> core_rx == $past(core_tx) && ack_error_ignore;
  endproperty
  a_loopback_rx: assert property (p_loopback_rx) else $error("loop back path wrong");

  c_auto_wake: cover property (@(posedge clk) disable iff (!rst_b)
    bus_activity && auto_wakeup_enable_reg);
  c_reach_normal: cover property (@(posedge clk) disable iff (!rst_b)
    $fell(sleep_acknowledge_reg) && !init_acknowledge_reg);
  c_enter_init: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(init_acknowledge_reg));
  c_combined: cover property (@(posedge clk) disable iff (!rst_b)
    core_active && loopback_select_reg && silent_select_reg);

endmodule

// ==== testbench/can_bus_node.sv ====
// far side of the bus: transceiver plus the other nodes on the wire
// assumes the bench says when some other node drives a dominant bit
`timescale 1ns/10ps

module can_bus_node
(
  // pins of the block
  input wire logic tx_pin,
  output logic rx_pin,
  // other nodes
  input wire logic other_dom
);
  // ------------------------------
  // wired-and bus
  // ------------------------------
  // termination pulls the bus recessive; any dominant driver wins
  assign rx_pin = tx_pin & ~other_dom;
endmodule

// ==== testbench/can_mode_control_tb_top.sv ====
// self-checking bench of the mode control block
// assumes the bus node model and the design files are compiled first
`timescale 1ns/10ps
`include "can_mode_consts.svh"

module can_mode_control_tb_top;
  localparam logic [31:0] ctl_a = 32'(`OFS_CONTROL);
  localparam logic [31:0] sts_a = 32'(`OFS_STATUS);
  localparam logic [31:0] irq_a = 32'(`OFS_IRQ_EN);
  localparam logic [31:0] dia_a = 32'(`OFS_DIAG);
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic core_tx = 1'b1;
  logic other_dom = 1'b0;
  logic rx_pin;
  logic tx_pin;
  logic core_rx;
  logic core_active;
  logic tx_start_allow;
  logic ack_error_ignore;
  logic wakeup_irq;
  logic [31:0] rd;
  logic [1:0] e;
  int mismatches = 0;
  int samples_checked = 0;
  integer seed = 32'h52ae;

  always #50 clk = ~clk;

  can_mode_control can_mode_control_i
  (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_receive_pin(rx_pin), .bus_transmit_pin(tx_pin),
    .core_tx(core_tx), .core_rx(core_rx), .core_active(core_active),
    .tx_start_allow(tx_start_allow), .ack_error_ignore(ack_error_ignore),
    .wakeup_irq(wakeup_irq)
  );

  can_bus_node can_bus_node_i
  (
    .tx_pin(tx_pin),
    .rx_pin(rx_pin),
    .other_dom(other_dom)
  );

  // ------------------------------
  // checking and bus tasks
  // ------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  // master waits for pready with no assumed latency, bounded by n
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    chk("pready", 32'h1, 32'(pready));
    chk("pslverr", 32'(a > 32'hc), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // polls the two acknowledges, long enough for a full bus sync
  task automatic wait_sts(input logic [1:0] exp);
    for (int i = 0; i < 80; i++)
    begin
      apb(1'b0, sts_a, 32'h0);
      if (rd[1:0] === exp)
        break;
    end
    chk("acknowledges", 32'(exp), 32'(rd[1:0]));
  endtask

  function automatic logic [1:0] exp_pins(input logic lbk, sil, ctx, oth);
    logic t;
    logic p;
    t = sil | ctx;
    p = t & ~oth;
    exp_pins = {t, lbk ? ctx : (sil ? p & ctx : p)};
  endfunction

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    print_verdict;
  end

  // ------------------------------
  // scenarios
  // ------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rdc("status", sts_a, 32'ha);
    rdc("control", ctl_a, 32'h2);
    chk("tx pin", 32'h1, 32'(tx_pin));
    apb(1'b0, 32'h10, 32'h0);
    chk("bad read", 32'h0, rd);
    wr_init_asleep: begin
      apb(1'b1, ctl_a, 32'h3);
      repeat (20) @(posedge clk);
      rdc("status", sts_a, 32'ha);
    end
    apb(1'b1, irq_a, 32'h1);
    apb(1'b1, ctl_a, 32'h0);
    // fewer than 11 bit times since the request
    repeat (90) @(posedge clk);
    chk("early active", 32'h0, 32'(core_active));
    wait_sts(2'h0);
    chk("active", 32'h1, 32'(core_active));
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, ctl_a, 32'h1);
      wait_sts(2'h1);
      core_tx <= 1'b0;
      repeat (3) @(posedge clk);
      chk("init tx pin", 32'h1, 32'(tx_pin));
      chk("init active", 32'h0, 32'(core_active));
      chk("init tx allow", 32'h0, 32'(tx_start_allow));
      core_tx <= 1'b1;
      rdc("irq enable", irq_a, 32'h1);
      apb(1'b1, dia_a, 32'(m));
      rdc("diag", dia_a, 32'(m) | 32'h4);
      apb(1'b1, ctl_a, 32'h0);
      wait_sts(2'h0);
      apb(1'b1, dia_a, 32'(~m) & 32'h3);
      rdc("diag held", dia_a, 32'(m) | 32'h4);
      chk("tx allow", 32'(!m[1]), 32'(tx_start_allow));
      chk("ack ignore", 32'(m[0]), 32'(ack_error_ignore));
      repeat (30)
      begin
        core_tx <= 1'($random(seed));
        other_dom <= 1'($random(seed));
        repeat (4) @(posedge clk);
        e = exp_pins(m[0], m[1], core_tx, other_dom);
        chk("tx pin", 32'(e[1]), 32'(tx_pin));
        chk("core rx", 32'(e[0]), 32'(core_rx));
      end
      core_tx <= 1'b1;
      other_dom <= 1'b0;
    end
    apb(1'b1, ctl_a, 32'h1);
    wait_sts(2'h1);
    apb(1'b1, dia_a, 32'h0);
    // wake-up by bus activity, automatic first, then by software
    for (int a = 1; a >= 0; a--)
    begin
      apb(1'b1, ctl_a, a ? 32'h6 : 32'h2);
      wait_sts(2'h2);
      other_dom <= 1'b1;
      repeat (3) @(posedge clk);
      other_dom <= 1'b0;
      repeat (3) @(posedge clk);
      chk("wake irq", 32'h1, 32'(wakeup_irq));
      rdc("control", ctl_a, a ? 32'h4 : 32'h2);
      rdc("asleep", sts_a, 32'he);
      if (a == 0)
        apb(1'b1, ctl_a, 32'h0);
      wait_sts(2'h0);
      apb(1'b1, sts_a, 32'h4);
      repeat (2) @(posedge clk);
      chk("wake irq clear", 32'h0, 32'(wakeup_irq));
    end
    print_verdict;
  end
endmodule
